// [src/tte_regs.vh]
/*
 Register offsets, field positions and encodings of the
 interrupt-triggered transfer engine and its descriptors.
 Assumes inclusion by bare name from the design files.
*/
`ifndef TTE_REGS_VH
`define TTE_REGS_VH
// Register byte offsets
`define TTE_OFF_VBASE 8'h00
`define TTE_OFF_IBASE 8'h04
`define TTE_OFF_OPER 8'h08
`define TTE_OFF_SEQ 8'h0c
`define TTE_OFF_DISP 8'h10
`define TTE_OFF_STAT 8'h14
// Operation register bits
`define TTE_OP_EN 0
`define TTE_OP_SHORT 1
`define TTE_OP_RSKIP 2
`define TTE_OP_STOP 3
// Sequence enable register
`define TTE_SEQ_EN 31
`define TTE_SEQ_SRC 7:0
// Descriptor word 0: mode a, mode b, mode c
`define TTE_MD 31:30
`define TTE_SZ 29:28
`define TTE_SM 27:26
`define TTE_WB_OFF_BIT 25
`define TTE_CHAIN_EN 23
`define TTE_CHAIN_ZERO 22
`define TTE_DM 21:20
`define TTE_AREA_SRC 19
`define TTE_IRQ_EACH 18
`define TTE_SEQ_END_BIT 17
`define TTE_INDEX_LOOKUP_BIT 16
`define TTE_DISP_EN 15
// Descriptor word 3: counters
`define TTE_CNTB 31:16
`define TTE_RLD 15:8
`define TTE_CNTA 7:0
// Transfer modes
`define TTE_MD_NORM 2'h0
`define TTE_MD_REPT 2'h1
`define TTE_MD_BLK 2'h2
// Address update modes
`define TTE_AM_FIX 2'h0
`define TTE_AM_INC 2'h1
`define TTE_AM_DEC 2'h2
// Sizes and strides
`define TTE_SZ_LONG 2'h2
`define TTE_DESC_STEP 32'h00000010
`define TTE_WI_LAST 2'h3
`define TTE_CNT8_ONE 8'h01
`define TTE_CNT16_ONE 16'h0001
// Bus responses
`define TTE_RESP_OKAY 2'h0
`define TTE_RESP_SLVERR 2'h2
`endif

// [src/tte_addr_step.v]
/*
 Address update for one side of a transfer: step by the
 unit size, optional displacement, short-space folding.
 Assumes a purely combinational use by the engine.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tte_regs.vh"
module tte_addr_step (
  // Current address and how it moves
  input wire [31:0] addr,
  input wire [1:0] mode,
  input wire [1:0] size,
  input wire [31:0] extra,
  input wire short_mode,
  // Updated address
  output reg [31:0] next
);
  reg [31:0] sum;
  always @* begin
    case (mode)
      `TTE_AM_INC: sum = addr + (32'h00000001 << size);
      `TTE_AM_DEC: sum = addr - (32'h00000001 << size);
      default: sum = addr;
    endcase
    sum = sum + extra;
    // Short space folds to the low 8 MB or the top 8 MB
    if (short_mode) begin
      next = {{8{sum[23]}}, sum[23:0]};
    end else begin
      next = sum;
    end
  end
endmodule
`default_nettype wire

// [src/tte_engine.v]
/*
 Interrupt-triggered transfer engine: AXI4-Lite register
 slave, trigger arbitration, descriptor fetch, data moves
 and write-back over a simple request/acknowledge master.
 Assumes memory acknowledges each request while it is held.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tte_regs.vh"
module tte_engine #(
  parameter N_CH = 8,
  parameter CH_W = 3
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite register slave
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // Trigger side
  input wire [N_CH-1:0] trig_req,
  output reg [N_CH-1:0] trig_ack,
  output reg cpu_irq,
  output reg [CH_W-1:0] cpu_irq_id,
  output reg event_req,
  // Memory master
  output reg mem_req,
  output reg mem_we,
  output reg [31:0] mem_addr,
  output reg [1:0] mem_size,
  output reg [31:0] mem_wdata,
  input wire mem_ack,
  input wire [31:0] mem_rdata
);
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_VEC = 4'h1;
  localparam [3:0] S_DRD = 4'h2;
  localparam [3:0] S_SRD = 4'h3;
  localparam [3:0] S_DWR = 4'h4;
  localparam [3:0] S_UPD = 4'h5;
  localparam [3:0] S_WB = 4'h6;
  localparam [3:0] S_NXT = 4'h7;
  localparam [3:0] S_IDX = 4'h8;

  reg [31:0] vbase_q, ibase_q, oper_q, seq_q, disp_q;
  reg aw_ok_q, w_ok_q;
  reg [7:0] awa_q;
  reg [31:0] wd_q;
  reg [3:0] ws_q;
  reg [31:0] rd_d;
  reg rd_err;
  reg [3:0] st_q;
  reg [CH_W-1:0] ch_q;
  reg [31:0] desc_q, cache_q, w0_q, sa_q, da_q, cnt_q, data_q;
  reg [31:0] seq_res_q;
  reg [7:0] seq_k_q, blk_q;
  reg [1:0] wi_q;
  reg cache_v_q, seq_run_q, seq_first_q, zero_q;
  reg pick_v;
  reg [CH_W-1:0] pick_id;
  integer i;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer b;
    begin
      for (b = 0; b < 4; b = b + 1) begin
        merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
      end
    end
  endfunction

  function [31:0] rewind;
    input [31:0] a;
    input [1:0] m;
    input [31:0] off;
    begin
      if (m == `TTE_AM_INC) begin
        rewind = a - off;
      end else if (m == `TTE_AM_DEC) begin
        rewind = a + off;
      end else begin
        rewind = a;
      end
    end
  endfunction

  // Descriptor fields
  wire [1:0] md = w0_q[`TTE_MD];
  wire [1:0] sz = w0_q[`TTE_SZ];
  wire [1:0] sm = w0_q[`TTE_SM];
  wire [1:0] dm = w0_q[`TTE_DM];
  wire wb_off = w0_q[`TTE_WB_OFF_BIT];
  wire [7:0] rld = cnt_q[`TTE_RLD];
  wire src_fix = (sm[1] == sm[0]);
  wire dst_fix = (dm[1] == dm[0]);
  wire short_m = oper_q[`TTE_OP_SHORT];
  // Zero in an 8-bit size field means 256 units
  wire [8:0] rlen = {(rld == 8'h00), rld};
  wire [10:0] roff = {2'b00, rlen} << sz;
  wire [31:0] roff32 = {21'h000000, roff};
  wire [31:0] sa_n, da_n;
  wire [31:0] disp_add = w0_q[`TTE_DISP_EN] ? disp_q : 32'h00000000;
  wire [N_CH-1:0] pend = trig_req & ~trig_ack;
  wire seq_hit = seq_q[`TTE_SEQ_EN] &&
    (seq_q[`TTE_SEQ_SRC] == {{(8-CH_W){1'b0}}, pick_id});
  wire rskip_ok = oper_q[`TTE_OP_RSKIP] && cache_v_q &&
    (cache_q == desc_q);
  wire wb_need = !wb_off && ((wi_q == 2'h3) ||
    (wi_q == 2'h1 && !src_fix) || (wi_q == 2'h2 && !dst_fix));
  wire [31:0] wb_word = (wi_q == 2'h1) ? sa_q :
    (wi_q == 2'h2) ? da_q : cnt_q;
  wire [31:0] desc_nx = desc_q + `TTE_DESC_STEP;
  wire go_chain = w0_q[`TTE_CHAIN_EN] &&
    (!w0_q[`TTE_CHAIN_ZERO] || zero_q);

  tte_addr_step u_src (
    .addr(sa_q),
    .mode(sm),
    .size(sz),
    .extra(disp_add),
    .short_mode(short_m),
    .next(sa_n)
  );

  tte_addr_step u_dst (
    .addr(da_q),
    .mode(dm),
    .size(sz),
    .extra(32'h00000000),
    .short_mode(short_m),
    .next(da_n)
  );

  // Lowest pending channel wins
  always @* begin
    pick_v = 1'b0;
    pick_id = {CH_W{1'b0}};
    for (i = N_CH - 1; i >= 0; i = i - 1) begin
      if (pend[i]) begin
        pick_v = 1'b1;
        pick_id = i[CH_W-1:0];
      end
    end
  end

  always @* begin
    rd_d = 32'h00000000;
    rd_err = 1'b0;
    case (araddr)
      `TTE_OFF_VBASE: rd_d = vbase_q;
      `TTE_OFF_IBASE: rd_d = ibase_q;
      `TTE_OFF_OPER: rd_d = oper_q;
      `TTE_OFF_SEQ: rd_d = seq_q;
      `TTE_OFF_DISP: rd_d = disp_q;
      `TTE_OFF_STAT: rd_d = {23'h000000, seq_run_q, 4'h0, st_q};
      default: rd_err = 1'b1;
    endcase
  end

  // One write at a time: ready returns after the response
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_ok_q <= 1'b0;
      w_ok_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `TTE_RESP_OKAY;
      vbase_q <= 32'h00000000;
      ibase_q <= 32'h00000000;
      oper_q <= 32'h00000000;
      seq_q <= 32'h00000000;
      disp_q <= 32'h00000000;
    end else begin
      if (awvalid && awready) begin
        awa_q <= awaddr;
        awready <= 1'b0;
        aw_ok_q <= 1'b1;
      end
      if (wvalid && wready) begin
        wd_q <= wdata;
        ws_q <= wstrb;
        wready <= 1'b0;
        w_ok_q <= 1'b1;
      end
      if (aw_ok_q && w_ok_q && !bvalid) begin
        aw_ok_q <= 1'b0;
        w_ok_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= `TTE_RESP_OKAY;
        case (awa_q)
          `TTE_OFF_VBASE: vbase_q <= merge(vbase_q, wd_q, ws_q);
          `TTE_OFF_IBASE: ibase_q <= merge(ibase_q, wd_q, ws_q);
          `TTE_OFF_OPER: oper_q <= merge(oper_q, wd_q, ws_q);
          `TTE_OFF_SEQ: seq_q <= merge(seq_q, wd_q, ws_q);
          `TTE_OFF_DISP: disp_q <= merge(disp_q, wd_q, ws_q);
          default: bresp <= `TTE_RESP_SLVERR;
        endcase
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `TTE_RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_d;
        rresp <= rd_err ? `TTE_RESP_SLVERR : `TTE_RESP_OKAY;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // Transfer engine
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= S_IDLE;
      ch_q <= {CH_W{1'b0}};
      desc_q <= 32'h00000000;
      cache_q <= 32'h00000000;
      cache_v_q <= 1'b0;
      w0_q <= 32'h00000000;
      sa_q <= 32'h00000000;
      da_q <= 32'h00000000;
      cnt_q <= 32'h00000000;
      data_q <= 32'h00000000;
      seq_res_q <= 32'h00000000;
      seq_k_q <= 8'h00;
      blk_q <= 8'h00;
      wi_q <= 2'h0;
      seq_run_q <= 1'b0;
      seq_first_q <= 1'b0;
      zero_q <= 1'b0;
      trig_ack <= {N_CH{1'b0}};
      cpu_irq <= 1'b0;
      cpu_irq_id <= {CH_W{1'b0}};
      event_req <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h00000000;
      mem_size <= `TTE_SZ_LONG;
      mem_wdata <= 32'h00000000;
    end else begin
      trig_ack <= {N_CH{1'b0}};
      cpu_irq <= 1'b0;
      event_req <= 1'b0;
      case (st_q)
        S_IDLE: begin
          // Stopped engine takes no triggers at all
          if (pick_v && !oper_q[`TTE_OP_STOP]) begin
            trig_ack <= {{(N_CH-1){1'b0}}, 1'b1} << pick_id;
            ch_q <= pick_id;
            wi_q <= 2'h0;
            if (!oper_q[`TTE_OP_EN]) begin
              cpu_irq <= 1'b1;
              cpu_irq_id <= pick_id;
            end else if (seq_hit && seq_run_q) begin
              desc_q <= seq_res_q;
              st_q <= S_DRD;
            end else begin
              seq_first_q <= seq_hit;
              seq_run_q <= seq_hit;
              st_q <= S_VEC;
            end
          end
        end
        S_VEC: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_size <= `TTE_SZ_LONG;
            mem_addr <= vbase_q + {{(30-CH_W){1'b0}}, ch_q, 2'b00};
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            desc_q <= mem_rdata;
            st_q <= S_DRD;
          end
        end
        S_DRD: begin
          if (!mem_req && wi_q == 2'h0 && rskip_ok) begin
            blk_q <= rld;
            st_q <= S_SRD;
          end else if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_size <= `TTE_SZ_LONG;
            mem_addr <= desc_q + {28'h0000000, wi_q, 2'b00};
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            wi_q <= wi_q + 2'h1;
            case (wi_q)
              2'h0: w0_q <= mem_rdata;
              2'h1: sa_q <= mem_rdata;
              2'h2: da_q <= mem_rdata;
              default: cnt_q <= mem_rdata;
            endcase
            if (wi_q == `TTE_WI_LAST) begin
              blk_q <= mem_rdata[`TTE_RLD];
              cache_q <= desc_q;
              cache_v_q <= !w0_q[`TTE_WB_OFF_BIT];
              st_q <= S_SRD;
            end
          end
        end
        S_SRD: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_size <= sz;
            mem_addr <= sa_q;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            data_q <= mem_rdata;
            st_q <= S_DWR;
          end
        end
        S_DWR: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_size <= sz;
            mem_addr <= da_q;
            mem_wdata <= data_q;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            st_q <= S_UPD;
          end
        end
        S_UPD: begin
          sa_q <= sa_n;
          da_q <= da_n;
          wi_q <= 2'h1;
          if (seq_first_q) begin
            seq_k_q <= data_q[7:0];
          end
          case (md)
            `TTE_MD_REPT: begin
              event_req <= 1'b1;
              st_q <= S_WB;
              cnt_q[`TTE_CNTA] <= cnt_q[`TTE_CNTA] - `TTE_CNT8_ONE;
              if (cnt_q[`TTE_CNTA] == `TTE_CNT8_ONE) begin
                cnt_q[`TTE_CNTA] <= rld;
                if (w0_q[`TTE_AREA_SRC]) begin
                  sa_q <= rewind(sa_n, sm, roff32);
                end else begin
                  da_q <= rewind(da_n, dm, roff32);
                end
              end
            end
            `TTE_MD_BLK: begin
              blk_q <= blk_q - `TTE_CNT8_ONE;
              if (blk_q == `TTE_CNT8_ONE) begin
                event_req <= 1'b1;
                cnt_q[`TTE_CNTB] <= cnt_q[`TTE_CNTB] - `TTE_CNT16_ONE;
                zero_q <= (cnt_q[`TTE_CNTB] == `TTE_CNT16_ONE);
                if (w0_q[`TTE_AREA_SRC]) begin
                  sa_q <= rewind(sa_n, sm, roff32);
                end else begin
                  da_q <= rewind(da_n, dm, roff32);
                end
                st_q <= S_WB;
              end else begin
                st_q <= S_SRD;
              end
            end
            default: begin
              event_req <= 1'b1;
              cnt_q[`TTE_CNTB] <= cnt_q[`TTE_CNTB] - `TTE_CNT16_ONE;
              zero_q <= (cnt_q[`TTE_CNTB] == `TTE_CNT16_ONE);
              st_q <= S_WB;
            end
          endcase
        end
        S_WB: begin
          if (!mem_req && wb_need) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_size <= `TTE_SZ_LONG;
            mem_addr <= desc_q + {28'h0000000, wi_q, 2'b00};
            mem_wdata <= wb_word;
          end else if (!mem_req || mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            wi_q <= wi_q + 2'h1;
            if (wi_q == `TTE_WI_LAST) begin
              st_q <= S_NXT;
            end
          end
        end
        S_NXT: begin
          wi_q <= 2'h0;
          zero_q <= 1'b0;
          if (w0_q[`TTE_IRQ_EACH] || zero_q) begin
            cpu_irq <= 1'b1;
            cpu_irq_id <= ch_q;
          end
          if (seq_first_q) begin
            seq_first_q <= 1'b0;
            if (w0_q[`TTE_INDEX_LOOKUP_BIT]) begin
              st_q <= S_IDX;
            end else begin
              desc_q <= ibase_q + {20'h00000, seq_k_q, 4'h0};
              st_q <= S_DRD;
            end
          end else if (seq_run_q) begin
            if (w0_q[`TTE_SEQ_END_BIT]) begin
              seq_run_q <= 1'b0;
              st_q <= S_IDLE;
            end else if (w0_q[`TTE_CHAIN_EN]) begin
              desc_q <= desc_nx;
              st_q <= S_DRD;
            end else begin
              seq_res_q <= desc_nx;
              st_q <= S_IDLE;
            end
          end else if (go_chain) begin
            desc_q <= desc_nx;
            st_q <= S_DRD;
          end else begin
            st_q <= S_IDLE;
          end
        end
        S_IDX: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_size <= `TTE_SZ_LONG;
            mem_addr <= ibase_q + {22'h000000, seq_k_q, 2'b00};
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            desc_q <= mem_rdata;
            st_q <= S_DRD;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// [testbench/tte_engine_sva.sv]
/*
 Port checker for the transfer engine.
 Assumes a bind to tte_engine and one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module tte_engine_sva #(
  parameter N_CH = 8,
  parameter CH_W = 3
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  // Trigger side
  input wire logic [N_CH-1:0] trig_req,
  input wire logic [N_CH-1:0] trig_ack,
  input wire logic cpu_irq,
  input wire logic event_req,
  // Memory master
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence aw_w_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence b_answer;
    !awready ##1 bvalid;
  endsequence
  wr_answer_a: assert property (aw_w_take |=> b_answer)
    else $error("write answer late");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  rd_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  mem_hold_a: assert property (mem_req && !mem_ack |=>
    mem_req && $stable({mem_we, mem_addr, mem_size, mem_wdata}))
    else $error("memory request changed");
  mem_gap_a: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request without gap");
  ack_cause_a: assert property (|trig_ack |-> $onehot(trig_ack) &&
    (trig_ack & $past(trig_req)) == trig_ack) else $error("ack without request");
  ack_pulse_a: assert property (|trig_ack |=> trig_ack == '0)
    else $error("ack too long");
  irq_pulse_a: assert property (cpu_irq |=> !cpu_irq)
    else $error("irq too long");
  event_pulse_a: assert property (event_req |=> !event_req)
    else $error("event too long");
endmodule
bind tte_engine tte_engine_sva #(.N_CH(N_CH), .CH_W(CH_W)) u_sva (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .trig_req(trig_req), .trig_ack(trig_ack),
  .cpu_irq(cpu_irq), .event_req(event_req), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata),
  .mem_ack(mem_ack)
);
`default_nettype wire

// [testbench/tte_mem_model.sv]
/*
 On-chip memory partner: byte store behind the request port.
 Assumes the bench presets contents and the wait count.
*/
`timescale 1ns/1ps
`default_nettype none
module tte_mem_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request side
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] wait_n,
  // Answer side
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [7:0] mem_b [0:1023];
  logic [3:0] cnt_q;
  logic [9:0] a;
  assign a = mem_addr[9:0];
  // Answers on the system clock, after wait_n cycles
  always @(posedge aclk) begin
    if (!aresetn) begin
      mem_ack <= 1'b0;
      cnt_q <= 4'h0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack && cnt_q == wait_n) begin
      mem_ack <= 1'b1;
      cnt_q <= 4'h0;
      mem_rdata <= {mem_b[a+3], mem_b[a+2], mem_b[a+1], mem_b[a]};
      if (mem_we)
        for (int i = 0; i < (1 << mem_size); i++)
          mem_b[a+i] <= mem_wdata[8*i+:8];
    end else begin
      mem_ack <= 1'b0;
      if (mem_req && !mem_ack)
        cnt_q <= cnt_q + 4'h1;
      // Released lines must not show the old word
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
/*
 Self-checking bench for the transfer engine.
 Assumes the memory model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tte_regs.vh"
module tb_top;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0, trig_req = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rd;
  logic [3:0] wstrb = 0, wait_n = 0;
  logic [1:0] rs;
  wire awready, wready, bvalid, arready, rvalid, cpu_irq, event_req;
  wire mem_req, mem_we, mem_ack;
  wire [1:0] bresp, rresp, mem_size;
  wire [31:0] rdata, mem_addr, mem_wdata, mem_rdata;
  wire [7:0] trig_ack;
  wire [2:0] cpu_irq_id;
  int miscompares = 0, n_checks = 0, n_ev = 0, n_irq = 0, n_ack = 0, k;
  initial forever #25 aclk = ~aclk;
  tte_engine dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .trig_req(trig_req), .trig_ack(trig_ack), .cpu_irq(cpu_irq),
    .cpu_irq_id(cpu_irq_id), .event_req(event_req), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  tte_mem_model ram (.aclk(aclk), .aresetn(aresetn), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size),
    .mem_wdata(mem_wdata), .wait_n(wait_n), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  always @(posedge aclk) begin
    n_ev <= n_ev + int'(event_req === 1'b1);
    n_irq <= n_irq + int'(cpu_irq === 1'b1);
    n_ack <= n_ack + int'(trig_ack !== 8'h00);
  end
  task automatic tally_and_finish;
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] pat(input int a);
    return {8'(a + 3), 8'(a + 2), 8'(a + 1), 8'(a)} ^ 32'h5a5a5a5a;
  endfunction
  function automatic logic [31:0] m32(input int a);
    return {ram.mem_b[a+3], ram.mem_b[a+2], ram.mem_b[a+1], ram.mem_b[a]};
  endfunction
  task automatic put(input int a, input logic [31:0] v);
    for (int i = 0; i < 4; i++)
      ram.mem_b[a+i] = v[8*i+:8];
  endtask
  task automatic desc(input int a, input logic [31:0] w0, w1, w2, w3);
    put(a, w0);
    put(a + 4, w1);
    put(a + 8, w2);
    put(a + 12, w3);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd, na, nw;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      na = awready & awvalid;
      nw = wready & wvalid;
      @(posedge aclk);
      if (na) awvalid <= 0;
      if (nw) wvalid <= 0;
      ad = ad | na;
      wd = wd | nw;
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    chk("bresp", er, bresp);
    @(posedge aclk);
    bready <= 0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    @(posedge aclk);
    rready <= 0;
  endtask
  task automatic trig(input int ch);
    @(posedge aclk);
    trig_req[ch] <= 1;
  endtask
  task automatic fin(input int ch);
    do @(negedge aclk); while (trig_ack[ch] !== 1'b1);
    @(posedge aclk);
    trig_req[ch] <= 0;
    do axr(8'h14); while (rd[3:0] !== 4'h0);
  endtask
  task automatic go(input int ch);
    trig(ch);
    fin(ch);
  endtask
  // Whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    tally_and_finish;
  end
  initial begin
    for (int i = 0; i < 1024; i++)
      ram.mem_b[i] = 8'(i) ^ 8'h5a;
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    for (int a = 0; a <= 24; a += 4) begin
      axr(8'(a));
      chk("reset value", 32'h0, rd);
      chk("rresp", (a == 24) ? `TTE_RESP_SLVERR : `TTE_RESP_OKAY, rs);
    end
    axw(8'h14, 32'h1, `TTE_RESP_SLVERR);
    axr(8'h14);
    chk("status", 32'h0, rd);
    axw(8'h00, 32'h100, `TTE_RESP_OKAY);
    axr(8'h00);
    chk("vector base", 32'h100, rd);
    put(32'h104, 32'h200);
    put(32'h10c, 32'h210);
    put(32'h110, 32'h200);
    // Engine off: trigger passes straight to the CPU
    go(2);
    chk("irq count", 1, n_irq);
    chk("irq id", 2, cpu_irq_id);
    axw(8'h08, 32'h3, `TTE_RESP_OKAY);
    desc(32'h200, 32'h24100000, 32'h007ffffc, 32'h340, 32'h00010000);
    put(32'h3fc, 32'ha5a51234);
    go(1);
    chk("normal data", 32'ha5a51234, m32(32'h340));
    chk("next unit", pat(32'h344), m32(32'h344));
    chk("short fold", 32'hff800000, m32(32'h204));
    chk("dst step", 32'h344, m32(32'h208));
    chk("count", 32'h0, m32(32'h20c));
    chk("event", 1, n_ev);
    chk("irq count", 2, n_irq);
    chk("irq id", 1, cpu_irq_id);
    axw(8'h08, 32'h1, `TTE_RESP_OKAY);
    desc(32'h200, 32'h84100000, 32'h300, 32'h380, 32'h00010303);
    go(1);
    chk("block bytes", (pat(32'h380) & 32'hff000000) | (pat(32'h300) & 32'h00ffffff),
      m32(32'h380));
    chk("block src", 32'h303, m32(32'h204));
    chk("block rewind", 32'h380, m32(32'h208));
    chk("block event", 2, n_ev);
    desc(32'h200, 32'h54080000, 32'h300, 32'h3c0, 32'h00000202);
    go(1);
    chk("repeat step", 32'h302, m32(32'h204));
    go(1);
    chk("repeat rewind", 32'h300, m32(32'h204));
    chk("repeat reload", 32'h2, m32(32'h20c) & 32'hff);
    chk("word unit", pat(32'h302) & 32'hffff, m32(32'h3c0) & 32'hffff);
    chk("repeat events", 4, n_ev);
    wait_n <= 4'h3;
    axw(8'h10, 32'h10, `TTE_RESP_OKAY);
    desc(32'h200, 32'h24908000, 32'h300, 32'h3e0, 32'h00050000);
    desc(32'h210, 32'h22000000, 32'h3a0, 32'h3f0, 32'h00030000);
    go(4);
    chk("chain first", pat(32'h300), m32(32'h3e0));
    chk("chain second", pat(32'h3a0), m32(32'h3f0));
    chk("displacement", 32'h314, m32(32'h204));
    chk("no writeback", 32'h00030000, m32(32'h21c));
    chk("chain events", 6, n_ev);
    axw(8'h08, 32'h9, `TTE_RESP_OKAY);
    k = n_ack;
    trig(3);
    repeat (20) @(posedge aclk);
    chk("stopped", k, n_ack);
    axw(8'h08, 32'h1, `TTE_RESP_OKAY);
    fin(3);
    chk("resumed", k + 1, n_ack);
    // Sequence on channel 5: first unit picks entry 1 of the index table
    axw(8'h04, 32'h240, `TTE_RESP_OKAY);
    axw(8'h0c, 32'h80000005, `TTE_RESP_OKAY);
    put(32'h114, 32'h220);
    desc(32'h220, 32'h22010000, 32'h3b0, 32'h3b4, 32'h00010000);
    desc(32'h250, 32'h22020000, 32'h3b8, 32'h3bc, 32'h00010000);
    put(32'h244, 32'h250);
    put(32'h3b0, 32'h1);
    put(32'h3b8, 32'h13572468);
    go(5);
    chk("sequence first", 32'h1, m32(32'h3b4));
    chk("sequence pick", 32'h13572468, m32(32'h3bc));
    chk("sequence end", 32'h0, rd & 32'h100);
    tally_and_finish;
  end
endmodule
`default_nettype wire
